// ### sepcp_core.v
// sepcp_core.v: spi eeprom slave instruction handling, protection and programming
// assumes spi pins already synchronous to clk_sys_i; memory array lives here
// How it works
// [R1] clear-latch opcode acts only on 8 clocks
// [R2] latch cleared on reset, clear opcode, programming end
// [R3] status byte repeats while selected
// [R4] status read allowed anytime, live flags
// [R5] new status bits apply after programming
// [R6] only lock and guard bits writable
// [R7] status write ignored when latch clear
// [R8] status write starts only on 16 clocks
// [R9] programming flag high exactly while programming
// [R10] lock bit plus low pin blocks status write
// [R11] read loads address, upper bits ignored
// [R12] read auto-increments with wrap to zero
// [R13] deselect ends read at once
// [R14] read refused while programming
// [R15] write starts on deselect after whole byte
// [R16] page write wraps low eight bits
// [R17] write refused unlatched, busy or guarded
// [R18] write needs 32 plus 8n clocks
// [R19] guard bits pick protected range
// [R20] high pin gives bit-guard mode only
// [R21] pin-lock mode entered either order
// [R22] pin-lock keeps unguarded array writable
// [R23] opcodes msb first, one byte
// [R24] status byte bit layout
// [R25] sample on sck rise, shift on fall
// [R26] set-latch opcode acts only on 8 clocks
`timescale 1ns/1ps
`include "sepcp_regs.vh"
module sepcp_core
#(
  parameter PROG_CYCLES = `SEPCP_PROGRAM_CYCLES,
  parameter PAGE_BYTES = 256
)
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire sel_n_i,
  input wire sck_i,
  input wire sdi_i,
  input wire pin_lock_n_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  output reg programming_flag_o,
  output reg write_latch_flag_o
);
  localparam S_IDLE = 6'b00_0001;
  localparam S_OPC = 6'b00_0010;
  localparam S_ADDR = 6'b00_0100;
  localparam S_RDATA = 6'b00_1000;
  localparam S_WDATA = 6'b01_0000;
  localparam S_SKIP = 6'b10_0000;

  reg [7:0] mem [0:(1<<`SEPCP_ADDR_W)-1];
  reg [7:0] page_buf [0:PAGE_BYTES-1];
  reg [PAGE_BYTES-1:0] page_vld_reg;

  reg [5:0] state_reg;
  reg sck_d_reg;
  reg sel_d_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_cnt_reg;
  reg [15:0] byte_cnt_reg;
  reg [7:0] opc_reg;
  reg [23:0] addr_sh_reg;
  reg [16:0] addr_reg;
  reg [7:0] tx_reg;

  reg status_lock_bit_reg;
  reg block_guard_hi_reg;
  reg block_guard_lo_reg;
  reg write_latch_flag_reg;
  reg [7:0] stat_new_reg;

  reg pend_stat_reg;
  reg pend_mem_reg;
  reg prog_reg;
  reg [31:0] prog_cnt_reg;
  reg [8:0] pidx_reg;
  reg rd_reload;
  reg [16:0] rd_addr_next;
  reg [7:0] rd_byte_next;

  wire sck_rise;
  wire sck_fall;
  wire frame_end;
  wire [7:0] rx_byte;
  wire guard_hit;
  wire pin_lock_mode;
  wire [7:0] status_live;

  assign sck_rise = ~sel_n_i & sck_i & ~sck_d_reg; // R25
  assign sck_fall = ~sel_n_i & ~sck_i & sck_d_reg; // R25
  assign frame_end = sel_n_i & ~sel_d_reg;
  assign rx_byte = {shift_reg[6:0], sdi_i}; // R23
  assign pin_lock_mode = status_lock_bit_reg & ~pin_lock_n_i; // R10 R21
  // b6..b4 read zero
  assign status_live = {status_lock_bit_reg, 3'b000, block_guard_hi_reg,
    block_guard_lo_reg, write_latch_flag_reg, prog_reg}; // R24 R6 R4

  sepcp_guard u_guard
  (
    .guard_i({block_guard_hi_reg, block_guard_lo_reg}),
    .addr_i(addr_reg),
    .hit_o(guard_hit)
  ); // R19

  // next byte of a running read; the first memory byte comes from tx_reg
  always @*
  begin
    rd_reload = 1'b0;
    rd_addr_next = addr_reg;
    rd_byte_next = 8'h00;
    if (bit_cnt_reg == 3'd0)
    begin
      if (opc_reg == `SEPCP_OP_STAT_RD && byte_cnt_reg > 16'd1)
      begin
        rd_reload = 1'b1; // R3
        rd_byte_next = status_live; // R4
      end
      else if (opc_reg == `SEPCP_OP_MEM_RD && byte_cnt_reg > 16'd4)
      begin
        rd_reload = 1'b1;
        rd_addr_next = addr_reg + 17'd1; // R12
        rd_byte_next = mem[rd_addr_next];
      end
    end
  end

  // pin history for edge detection
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sck_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
    end
    else
    begin
      sck_d_reg <= sck_i;
      sel_d_reg <= sel_n_i;
    end
  end

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      programming_flag_o <= 1'b0;
      write_latch_flag_o <= 1'b0;
    end
    else
    begin
      programming_flag_o <= prog_reg; // R9
      write_latch_flag_o <= write_latch_flag_reg; // R2
    end
  end

  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 3'd0;
      byte_cnt_reg <= 16'h0000;
      opc_reg <= 8'h00;
      addr_sh_reg <= 24'h00_0000;
      addr_reg <= 17'h0_0000;
      tx_reg <= 8'h00;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      status_lock_bit_reg <= 1'b0;
      block_guard_hi_reg <= 1'b0;
      block_guard_lo_reg <= 1'b0;
      write_latch_flag_reg <= 1'b0; // R2
      stat_new_reg <= 8'h00;
      pend_stat_reg <= 1'b0;
      pend_mem_reg <= 1'b0;
      prog_reg <= 1'b0;
      prog_cnt_reg <= 32'h0000_0000;
      pidx_reg <= 9'd0;
      page_vld_reg <= {PAGE_BYTES{1'b0}};
    end
    else
    begin
      // internal programming timer
      if (prog_reg)
      begin
        if (pend_mem_reg)
        begin
          if (page_vld_reg[pidx_reg[7:0]])
            mem[{addr_reg[16:8], pidx_reg[7:0]}] <= page_buf[pidx_reg[7:0]];
          if (pidx_reg != 9'd256)
            pidx_reg <= pidx_reg + 9'd1;
        end
        if (prog_cnt_reg >= PROG_CYCLES - 1)
        begin
          prog_reg <= 1'b0; // R9
          write_latch_flag_reg <= 1'b0; // R2 R15
          pend_mem_reg <= 1'b0;
          if (pend_stat_reg)
          begin
            status_lock_bit_reg <= stat_new_reg[`SEPCP_ST_LOCK]; // R5 R6
            block_guard_hi_reg <= stat_new_reg[`SEPCP_ST_GUARD_HI];
            block_guard_lo_reg <= stat_new_reg[`SEPCP_ST_GUARD_LO];
          end
          pend_stat_reg <= 1'b0;
        end
        else
          prog_cnt_reg <= prog_cnt_reg + 32'd1;
      end

      if (frame_end)
      begin
        state_reg <= S_IDLE; // R13
        sdo_oe_o <= 1'b0;
        if (state_reg == S_OPC && bit_cnt_reg == 3'd0 && byte_cnt_reg == 16'd1 && !prog_reg)
        begin
          if (opc_reg == `SEPCP_OP_SET_LATCH)
            write_latch_flag_reg <= 1'b1; // R26
          else if (opc_reg == `SEPCP_OP_CLR_LATCH)
            write_latch_flag_reg <= 1'b0; // R1 R2
        end
        // status write: exactly 16 clocks
        if (state_reg == S_OPC && opc_reg == `SEPCP_OP_STAT_WR && byte_cnt_reg == 16'd2
          && bit_cnt_reg == 3'd0 && write_latch_flag_reg && !pin_lock_mode && !prog_reg)
        begin
          pend_stat_reg <= 1'b1; // R7 R8 R10 R20
          prog_reg <= 1'b1; // R9
          prog_cnt_reg <= 32'h0000_0000;
        end
        // memory write: 32 + 8n clocks
        if (state_reg == S_WDATA && bit_cnt_reg == 3'd0 && byte_cnt_reg > 16'd4)
        begin
          pend_mem_reg <= 1'b1; // R15 R18
          prog_reg <= 1'b1;
          prog_cnt_reg <= 32'h0000_0000;
          pidx_reg <= 9'd0;
        end
      end
      else if (sel_n_i)
      begin
        bit_cnt_reg <= 3'd0;
        byte_cnt_reg <= 16'h0000;
        if (!prog_reg)
          page_vld_reg <= {PAGE_BYTES{1'b0}};
        state_reg <= S_OPC;
      end
      else
      begin
        if (sck_rise && state_reg != S_SKIP)
        begin
          shift_reg <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 3'd1;
          if (bit_cnt_reg == 3'd7)
            byte_cnt_reg <= byte_cnt_reg + 16'd1;
        end

        if (sck_rise)
        begin
          case (state_reg)
            S_OPC:
            begin
              if (bit_cnt_reg == 3'd7 && byte_cnt_reg == 16'd0)
              begin
                opc_reg <= rx_byte;
                if (rx_byte == `SEPCP_OP_STAT_RD)
                begin
                  tx_reg <= status_live; // R3 R4
                  state_reg <= S_RDATA;
                end
                else if (rx_byte == `SEPCP_OP_MEM_RD)
                  state_reg <= prog_reg ? S_SKIP : S_ADDR; // R14
                else if (rx_byte == `SEPCP_OP_MEM_WR)
                  state_reg <= (prog_reg || !write_latch_flag_reg) ? S_SKIP : S_ADDR; // R17
                else if (rx_byte != `SEPCP_OP_SET_LATCH && rx_byte != `SEPCP_OP_CLR_LATCH
                  && rx_byte != `SEPCP_OP_STAT_WR)
                  state_reg <= S_SKIP;
              end
              else if (bit_cnt_reg == 3'd7 && byte_cnt_reg == 16'd1)
                stat_new_reg <= rx_byte;
            end

            S_ADDR:
            begin
              addr_sh_reg <= {addr_sh_reg[22:0], sdi_i};
              if (bit_cnt_reg == 3'd7 && byte_cnt_reg == 16'd3)
              begin
                addr_reg <= {addr_sh_reg[15:0], sdi_i}; // R11
                if (opc_reg == `SEPCP_OP_MEM_RD)
                begin
                  tx_reg <= mem[{addr_sh_reg[15:0], sdi_i}]; // R11
                  state_reg <= S_RDATA;
                end
                else
                  state_reg <= S_WDATA;
              end
            end

            S_WDATA:
            begin
              if (guard_hit)
                state_reg <= S_SKIP; // R17 R22
              else if (bit_cnt_reg == 3'd7)
              begin
                page_buf[addr_reg[7:0]] <= rx_byte;
                page_vld_reg[addr_reg[7:0]] <= 1'b1;
                addr_reg[7:0] <= addr_reg[7:0] + 8'd1; // R16
              end
            end

            default:
            begin
            end
          endcase
        end

        if (sck_fall && state_reg == S_RDATA)
        begin
          sdo_oe_o <= 1'b1;
          if (rd_reload)
          begin
            sdo_o <= rd_byte_next[7]; // R3 R12
            tx_reg <= {rd_byte_next[6:0], 1'b0};
            addr_reg <= rd_addr_next; // R12
          end
          else
          begin
            sdo_o <= tx_reg[7]; // R25
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule // sepcp_core

// ### sepcp_core_sva.sv
// sepcp_core_sva: port checker for the eeprom command block
// assumes binding onto sepcp_core; one clock domain
`timescale 1ns/1ps
module sepcp_core_sva
#(
  parameter PROG_CYCLES = 20
)
(
  input wire clk_sys_i,
  input wire rst_i,
  input wire sel_n_i,
  input wire sck_i,
  input wire sdo_o,
  input wire sdo_oe_o,
  input wire programming_flag_o,
  input wire write_latch_flag_o
);
  int run_cnt;
  always @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      run_cnt <= 0;
    else
      run_cnt <= programming_flag_o ? run_cnt + 1 : 0;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  oe_sel_a: assert property (sdo_oe_o |-> !$past(sel_n_i))
    else $error("drive while deselected");
  sdo_hold_a: assert property (sck_i && $past(sck_i) && $past(sck_i, 2)
    |-> $stable(sdo_o))
    else $error("sdo moved while sck high");
  prog_start_a: assert property ($rose(programming_flag_o) |-> $past(sel_n_i))
    else $error("programming began while selected");
  prog_latch_a: assert property ($rose(programming_flag_o) |-> write_latch_flag_o)
    else $error("programming without latch");
  prog_len_a: assert property ($fell(programming_flag_o)
    |-> run_cnt >= PROG_CYCLES && run_cnt <= PROG_CYCLES + 1)
    else $error("programming length wrong");
  latch_end_a: assert property ($fell(programming_flag_o) |-> ##[0:1] !write_latch_flag_o)
    else $error("latch kept after programming");
  latch_set_a: assert property ($rose(write_latch_flag_o) |-> $past(sel_n_i))
    else $error("latch set while selected");
  latch_drop_a: assert property ($fell(write_latch_flag_o)
    |-> $past(sel_n_i) || $past(programming_flag_o, 2))
    else $error("latch cleared without cause");
endmodule // sepcp_core_sva
bind sepcp_core sepcp_core_sva #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .sel_n_i(sel_n_i), .sck_i(sck_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .programming_flag_o(programming_flag_o), .write_latch_flag_o(write_latch_flag_o));

// ### sepcp_guard.v
// sepcp_guard.v: decides whether an address lies in the guarded block
// assumes the guard bits come from the status register
`timescale 1ns/1ps
`include "sepcp_regs.vh"
module sepcp_guard
(
  input wire [1:0] guard_i,
  input wire [16:0] addr_i,
  output reg hit_o
);
  always @*
  begin
    case (guard_i)
      2'b00: hit_o = 1'b0;
      2'b01: hit_o = (addr_i >= `SEPCP_QUARTER_BASE);
      2'b10: hit_o = (addr_i >= `SEPCP_HALF_BASE);
      default: hit_o = 1'b1;
    endcase
  end
endmodule // sepcp_guard

// ### sepcp_host.sv
// sepcp_host: spi host model framing instructions for the command block
// assumes the system clock; each sck level held 3 clk, msb first
`timescale 1ns/1ps
module sepcp_host
(
  input wire clk_i,
  input wire sdo_i,
  output reg sel_n_o,
  output reg sck_o,
  output reg sdi_o
);
  initial
  begin
    sel_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  task sel(input logic s);
    begin
      @(posedge clk_i) sel_n_o <= s;
      sdi_o <= ~sdi_o;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task bits(input [31:0] v, input int n, output [31:0] q);
    int i;
    begin
      q = 32'h0;
      for (i = n - 1; i >= 0; i--)
      begin
        @(posedge clk_i) sdi_o <= v[i];
        repeat (2) @(posedge clk_i);
        sck_o <= 1'b1;
        q = {q[30:0], sdo_i};
        repeat (3) @(posedge clk_i);
        sck_o <= 1'b0;
      end
    end
  endtask
endmodule // sepcp_host

// ### sepcp_regs.vh
// sepcp_regs.vh: opcodes, status layout, protect ranges, timing of the eeprom command logic
// assumes inclusion by the design files of the command block
`ifndef SEPCP_REGS_VH
`define SEPCP_REGS_VH
`define SEPCP_OP_SET_LATCH 8'h06
`define SEPCP_OP_CLR_LATCH 8'h04
`define SEPCP_OP_STAT_RD 8'h05
`define SEPCP_OP_STAT_WR 8'h01
`define SEPCP_OP_MEM_RD 8'h03
`define SEPCP_OP_MEM_WR 8'h02
`define SEPCP_ST_LOCK 7
`define SEPCP_ST_GUARD_HI 3
`define SEPCP_ST_GUARD_LO 2
`define SEPCP_ST_LATCH 1
`define SEPCP_ST_PROG 0
`define SEPCP_STAT_RESET 8'h00
`define SEPCP_QUARTER_BASE 17'h1_8000
`define SEPCP_HALF_BASE 17'h1_0000
`define SEPCP_ADDR_W 17
`define SEPCP_PROGRAM_TIME_NS 5000000
`define SEPCP_CLK_PERIOD_NS 5
`define SEPCP_PROGRAM_CYCLES (`SEPCP_PROGRAM_TIME_NS / `SEPCP_CLK_PERIOD_NS)
`endif

// ### tb_top.sv
// tb_top: self-checking bench of the eeprom command block
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin_lock_n_i = 1'b1;
  wire sel_n, sck, sdi, sdo, oe, prog_f, latch_f;
  logic [31:0] r;
  logic [16:0] in_a [1:3];
  int error_cnt = 0;
  int n_tests = 0;
  int g;
  always #2.5 clk_sys_i = ~clk_sys_i;
  sepcp_core #(.PROG_CYCLES(400)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sel_n_i(sel_n),
    .sck_i(sck), .sdi_i(sdi), .pin_lock_n_i(pin_lock_n_i), .sdo_o(sdo), .sdo_oe_o(oe),
    .programming_flag_o(prog_f), .write_latch_flag_o(latch_f));
  sepcp_host h (.clk_i(clk_sys_i), .sdo_i(sdo), .sel_n_o(sel_n), .sck_o(sck), .sdi_o(sdi));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("MISMATCH %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task short(input [31:0] v, input int n);
    begin
      h.sel(1'b0);
      h.bits(v, n, r);
      h.sel(1'b1);
    end
  endtask
  task xfer(input [7:0] op, input [23:0] a, input [15:0] d, input int n);
    begin
      h.sel(1'b0);
      h.bits({op, a}, 32, r);
      h.bits({16'h0, d}, n, r);
      h.sel(1'b1);
    end
  endtask
  task st_rd(input [7:0] e);
    begin
      short(32'h0005_0000, 24);
      chk(r[15:0], {e, e});
    end
  endtask
  task busy(input e);
    int k;
    begin
      repeat (3) @(posedge clk_sys_i);
      chk(prog_f, e);
      for (k = 0; k < 900 && prog_f !== 1'b0; k++)
        @(posedge clk_sys_i);
    end
  endtask
  task t_latch;
    begin
      st_rd(8'h00);
      short(32'h06, 7);
      st_rd(8'h00);
      short(32'h06, 8);
      chk(latch_f, 1'b1);
      short(32'h08, 9);
      st_rd(8'h02);
      short(32'h04, 8);
      st_rd(8'h00);
      $display("latch test done");
    end
  endtask
  task t_stwr;
    begin
      short(32'h01FF, 16);
      busy(1'b0);
      short(32'h06, 8);
      short(32'h03FE, 17);
      busy(1'b0);
      short(32'h01FF, 16);
      st_rd(8'h03);
      busy(1'b1);
      st_rd(8'h8C);
      $display("status write test done");
    end
  endtask
  task t_hw;
    begin
      @(posedge clk_sys_i) pin_lock_n_i <= 1'b0;
      short(32'h06, 8);
      short(32'h0100, 16);
      busy(1'b0);
      st_rd(8'h8E);
      @(posedge clk_sys_i) pin_lock_n_i <= 1'b1;
      short(32'h0100, 16);
      busy(1'b1);
      @(posedge clk_sys_i) pin_lock_n_i <= 1'b0;
      short(32'h06, 8);
      short(32'h0180, 16);
      busy(1'b1);
      short(32'h06, 8);
      short(32'h0100, 16);
      busy(1'b0);
      xfer(8'h02, 24'h00_0040, 16'h0077, 8);
      busy(1'b1);
      @(posedge clk_sys_i) pin_lock_n_i <= 1'b1;
      short(32'h06, 8);
      short(32'h0100, 16);
      busy(1'b1);
      $display("pin lock test done");
    end
  endtask
  task t_mem;
    begin
      short(32'h06, 8);
      xfer(8'h02, 24'hFE_12FF, 16'hA55A, 16);
      busy(1'b1);
      st_rd(8'h00);
      xfer(8'h03, 24'h00_1200, 16'h0, 8);
      chk(r[7:0], 8'h5A);
      short(32'h06, 8);
      xfer(8'h02, 24'h01_FFFF, 16'h003C, 8);
      busy(1'b1);
      short(32'h06, 8);
      xfer(8'h02, 24'h00_0000, 16'h00C3, 8);
      busy(1'b1);
      xfer(8'h03, 24'h01_FFFF, 16'h0, 16);
      chk(r[15:0], 16'h3CC3);
      xfer(8'h02, 24'h00_0100, 16'h0011, 8);
      busy(1'b0);
      short(32'h06, 8);
      xfer(8'h02, 24'h00_0100, 16'h0011, 9);
      busy(1'b0);
      xfer(8'h02, 24'h00_0100, 16'h0011, 8);
      h.sel(1'b0);
      h.bits(32'h0300_0100, 32, r);
      chk(oe, 1'b0);
      h.sel(1'b1);
      busy(1'b1);
      $display("memory test done");
    end
  endtask
  task t_guard;
    begin
      in_a = '{17'h1_8000, 17'h1_0000, 17'h0_0000};
      for (g = 1; g < 4; g++)
      begin
        short(32'h06, 8);
        short(32'h0100 | (g << 2), 16);
        busy(1'b1);
        short(32'h06, 8);
        xfer(8'h02, {7'h0, in_a[g]}, 16'h0, 8);
        busy(1'b0);
        xfer(8'h02, {7'h0, in_a[g] - 17'h1}, 16'h0, 8);
        busy(g < 3);
      end
      $display("guard test done");
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    t_latch;
    t_stwr;
    t_hw;
    t_mem;
    t_guard;
    conclude;
  end
  initial
  begin
    #300000;
    error_cnt++;
    conclude;
  end
endmodule // tb_top
